// *** hdl/scan_layer_map.svh ***
// Purpose : register offsets, field positions, reset values and counts for the
//           display scan and layer control block
// Assumes : 16-bit registers reached by word index on a plain register port
// Notes   : definitions only; guarded against double inclusion
`ifndef SCAN_LAYER_MAP_SVH
`define SCAN_LAYER_MAP_SVH

// register indices
`define OFS_DISPLAY_MODE_ONE   3'h0
`define OFS_DISPLAY_MODE_TWO   3'h1
`define OFS_RENDERING_MODE     3'h2
`define OFS_BACKDROP_ORIGIN_X  3'h3
`define OFS_BACKDROP_ORIGIN_Y  3'h4
`define OFS_SCAN_STATUS        3'h5

// display_mode_one fields
`define POS_SCAN_MODE_LO       0
`define POS_SYNC_SOURCE_LO     2
`define POS_BACKDROP_ENABLE    10
`define POS_BACKDROP_WRAP      11

// display_mode_two fields
`define POS_FRONT_ENABLE       0
`define POS_VIDEO_ENABLE       1
`define POS_POINTER1_ENABLE    2
`define POS_POINTER2_ENABLE    3
`define POS_FIELD_ORDER        4

// rendering_mode and origin fields
`define POS_PIXEL_DEPTH_LO     0
`define WID_PIXEL_DEPTH        3
`define WID_ORIGIN_X           10
`define WID_ORIGIN_Y           14
`define DEPTH_CODE_8BPP        3'h0

// reset values
`define RST_DISPLAY_MODE_ONE   16'h0000
`define RST_DISPLAY_MODE_TWO   16'h0001
`define RST_RENDERING_MODE     16'h0000
`define RST_ORIGIN             16'h0000

// backdrop plane size in pixels
`define BACKDROP_WIDTH         1024
`define BACKDROP_HEIGHT        1024

`endif

// *** hdl/scan_layer_pkg.sv ***
// Purpose : shared types of the display scan and layer control block
// Assumes : constants live in scan_layer_map.svh
// Notes   : encodings of scan and sync modes are held here as enums
package scan_layer_pkg;

    // scan system codes
    typedef enum logic [1:0] {
        SCAN_NON_INTERLACE = 2'b00,
        SCAN_RESERVED      = 2'b01,
        SCAN_INTERLACE     = 2'b10,
        SCAN_SYNC_VIDEO    = 2'b11
    } scan_mode_t;

    // timing source codes
    typedef enum logic [1:0] {
        SYNC_MASTER    = 2'b00,
        SYNC_SWITCHING = 2'b01,
        SYNC_EXTERNAL  = 2'b10,
        SYNC_SPARE     = 2'b11
    } sync_source_t;

    // per-layer display and fetch enables
    typedef struct packed {
        logic front;
        logic video;
        logic backdrop;
        logic pointer1;
        logic pointer2;
    } layer_enables_t;

    // current field as seen by the rest of the display path
    typedef struct packed {
        logic even;
        logic first;
        logic interlaced;
    } field_state_t;

endpackage : scan_layer_pkg

// *** hdl/field_tracker.sv ***
// Purpose : field sequencing and field indicator pin handling
// Assumes : field_start is a one-cycle pulse on core_clk at each field start
// Notes   : pin input arrives from outside and is synchronised here
module field_tracker (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        field_start,
    input  wire scan_layer_pkg::scan_mode_t  scan_mode,
    input  wire scan_layer_pkg::sync_source_t sync_source,
    input  wire logic                        field_order,
    input  wire logic                        pin_in,
    output logic                             pin_out,
    output logic                             pin_oe,
    output scan_layer_pkg::field_state_t     field
);

    logic pin_meta;
    logic pin_sync;
    logic interlaced;
    logic external;
    logic first_field;
    logic next_even;

    assign interlaced = (scan_mode == scan_layer_pkg::SCAN_INTERLACE) ||
                        (scan_mode == scan_layer_pkg::SCAN_SYNC_VIDEO);
    assign external   = (sync_source == scan_layer_pkg::SYNC_EXTERNAL);

    // two-flop synchroniser for the field indicator pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // in slave timing the pin says the parity; its sense flips with field order
    assign next_even = external ? (pin_sync ^ field_order)
                                : (first_field ? field_order : ~field_order);

    // field parity and first-of-frame flag move only at a field start
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            first_field <= 1'b1;
            field       <= '0;
        end else if (field_start) begin
            if (!interlaced) begin
                first_field <= 1'b1;
                field       <= '{even: 1'b0, first: 1'b1, interlaced: 1'b0};
            end else begin
                // order 0 shows odd then even, order 1 even then odd
                first_field <= external ? (next_even != field_order) : ~first_field;
                field       <= '{even: next_even,
                                 first: external ? (next_even == field_order) : first_field,
                                 interlaced: 1'b1};
            end
        end
    end

    // in interlaced scans master drives high in even fields when order is 0, inverted when 1
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= field.even ^ field_order;
            pin_oe  <= !external && field.interlaced;
        end
    end

endmodule : field_tracker

// *** hdl/display_scan_layer_control.sv ***
// Purpose : scan system and screen layer control of a display controller
// Assumes : timing generator, fetch engine and palette sit outside this block
// Notes   : all logic on core_clk; only the field indicator pin is asynchronous
// Operation
// - each layer shows only when its enable bit is set
// - backdrop enable at bit 10 of display mode one switches backdrop
// - wrap bit at 11 chooses wraparound or plain non-wrapping scroll
// - three-bit depth field chooses 8 or 16 bits per pixel for front layer
// - backdrop origin is 10-bit X and 14-bit Y in screen coordinates
// - scan code 00 is non-interlace: one field per frame
// - scan code 10 is interlace: two fields show the same frame data
// - sync and video interlace: two fields carry different image data
// - scan code 11 selects interlace sync and video scanning
// - field order 0 shows odd then even; 1 shows even then odd
// - master timing drives field pin high in even, low in odd fields; the pin is left undriven in non-interlace
// - external source drives field pin high for even; device reads likewise
// - field order 1 inverts field pin polarity in both timing modes
// - two-bit sync field chooses master timing or external sync slaving
// - only enabled layers are fetched from graphics memory
// - non-interlace samples video buffer status once per field
// - interlace samples video buffer status once per frame
module display_scan_layer_control #(
    parameter int PIXEL_WIDTH = 16,
    parameter int ADDR_WIDTH  = 3,
    parameter int SCAN_X_W    = 10,
    parameter int SCAN_Y_W    = 14
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // register port
    input  wire logic [ADDR_WIDTH-1:0]      reg_addr,
    input  wire logic [15:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [15:0]                reg_rdata,
    // timing from the sync generator
    input  wire logic                       field_start,
    input  wire logic                       pixel_valid,
    input  wire logic [SCAN_X_W-1:0]        scan_x,
    input  wire logic [SCAN_Y_W-1:0]        scan_y,
    // field indicator pin, split into its three signals
    input  wire logic                       field_indicator_pin_in,
    output logic                            field_indicator_pin_out,
    output logic                            field_indicator_pin_oe,
    // video capture side
    input  wire logic                       video_buffer_status,
    output logic                            video_buffer_shown,
    output logic                            video_capture_mode_ok,
    // fetch control towards graphics memory
    output scan_layer_pkg::layer_enables_t  fetch_enables,
    output logic                            front_depth_16,
    output logic [SCAN_X_W-1:0]             backdrop_fetch_x,
    output logic [SCAN_Y_W-1:0]             backdrop_fetch_y,
    output logic                            backdrop_fetch_valid,
    output scan_layer_pkg::field_state_t    field_state,
    // layer pixels back from the fetch engine
    input  wire logic [PIXEL_WIDTH-1:0]     front_pixel,
    input  wire logic [PIXEL_WIDTH-1:0]     video_pixel,
    input  wire logic                       video_in_window,
    input  wire logic [PIXEL_WIDTH-1:0]     backdrop_pixel,
    input  wire logic [PIXEL_WIDTH-1:0]     pointer1_pixel,
    input  wire logic [PIXEL_WIDTH-1:0]     pointer2_pixel,
    output logic      [PIXEL_WIDTH-1:0]     composed_pixel,
    output logic                            composed_valid
);

    `include "scan_layer_map.svh"

    localparam logic [SCAN_X_W:0] BG_W = (SCAN_X_W+1)'(`BACKDROP_WIDTH);
    localparam logic [SCAN_Y_W:0] BG_H = (SCAN_Y_W+1)'(`BACKDROP_HEIGHT);

    // software-visible registers
    logic [15:0] display_mode_one;
    logic [15:0] display_mode_two;
    logic [15:0] rendering_mode;
    logic [15:0] backdrop_origin_x;
    logic [15:0] backdrop_origin_y;

    // decoded control
    scan_layer_pkg::scan_mode_t     scan_mode;
    scan_layer_pkg::sync_source_t   sync_source;
    scan_layer_pkg::layer_enables_t layer_on;
    logic                           backdrop_wrap;
    logic                           field_order;
    logic [`WID_PIXEL_DEPTH-1:0]    pixel_depth_select;

    // backdrop address path
    logic [SCAN_X_W:0] sum_x;
    logic [SCAN_Y_W:0] sum_y;
    logic [SCAN_X_W:0] next_fetch_x;
    logic [SCAN_Y_W:0] next_fetch_y;
    logic              next_bg_inside;

    // composition
    logic [PIXEL_WIDTH-1:0] next_pixel;
    logic                   buffer_sample;

    // word-index decode shared by reads and writes
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                 input logic [2:0]            ofs);
        hit = (a == ADDR_WIDTH'(ofs));
    endfunction : hit

    // writable registers; updates take effect on the next clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            display_mode_one  <= `RST_DISPLAY_MODE_ONE;
            display_mode_two  <= `RST_DISPLAY_MODE_TWO;
            rendering_mode    <= `RST_RENDERING_MODE;
            backdrop_origin_x <= `RST_ORIGIN;
            backdrop_origin_y <= `RST_ORIGIN;
        end else if (reg_wr) begin
            if (hit(reg_addr, `OFS_DISPLAY_MODE_ONE)) begin
                display_mode_one <= reg_wdata;
            end else if (hit(reg_addr, `OFS_DISPLAY_MODE_TWO)) begin
                display_mode_two <= reg_wdata;
            end else if (hit(reg_addr, `OFS_RENDERING_MODE)) begin
                rendering_mode <= reg_wdata;
            end else if (hit(reg_addr, `OFS_BACKDROP_ORIGIN_X)) begin
                // only ten bits are kept, the rest read as zero
                backdrop_origin_x <= {6'h00, reg_wdata[`WID_ORIGIN_X-1:0]};
            end else if (hit(reg_addr, `OFS_BACKDROP_ORIGIN_Y)) begin
                backdrop_origin_y <= {2'h0, reg_wdata[`WID_ORIGIN_Y-1:0]};
            end
        end
    end

    // field decode of the mode registers
    assign scan_mode   = scan_layer_pkg::scan_mode_t'(
                         display_mode_one[`POS_SCAN_MODE_LO +: 2]);
    assign sync_source = scan_layer_pkg::sync_source_t'(
                         display_mode_one[`POS_SYNC_SOURCE_LO +: 2]);
    assign backdrop_wrap      = display_mode_one[`POS_BACKDROP_WRAP];
    assign field_order        = display_mode_two[`POS_FIELD_ORDER];
    assign pixel_depth_select = rendering_mode[`POS_PIXEL_DEPTH_LO +: `WID_PIXEL_DEPTH];

    // each layer has its own enable: backdrop in mode one, the rest in mode two
    assign layer_on.front    = display_mode_two[`POS_FRONT_ENABLE];
    assign layer_on.video    = display_mode_two[`POS_VIDEO_ENABLE];
    assign layer_on.backdrop = display_mode_one[`POS_BACKDROP_ENABLE];
    assign layer_on.pointer1 = display_mode_two[`POS_POINTER1_ENABLE];
    assign layer_on.pointer2 = display_mode_two[`POS_POINTER2_ENABLE];

    // read data stands in the cycle after the strobe and only there
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (hit(reg_addr, `OFS_DISPLAY_MODE_ONE)) begin
            reg_rdata <= display_mode_one;
        end else if (hit(reg_addr, `OFS_DISPLAY_MODE_TWO)) begin
            reg_rdata <= display_mode_two;
        end else if (hit(reg_addr, `OFS_RENDERING_MODE)) begin
            reg_rdata <= rendering_mode;
        end else if (hit(reg_addr, `OFS_BACKDROP_ORIGIN_X)) begin
            reg_rdata <= backdrop_origin_x;
        end else if (hit(reg_addr, `OFS_BACKDROP_ORIGIN_Y)) begin
            reg_rdata <= backdrop_origin_y;
        end else if (hit(reg_addr, `OFS_SCAN_STATUS)) begin
            // live view of field and buffer state for software polling
            reg_rdata <= {11'h000, front_depth_16, video_buffer_shown,
                          field_state.interlaced, field_state.first, field_state.even};
        end else begin
            reg_rdata <= 16'h0000;   // unmapped index reads as zero
        end
    end

    // field sequencing and the field indicator pin
    field_tracker u_field (
        .core_clk    (core_clk),
        .rst         (rst),
        .field_start (field_start),
        .scan_mode   (scan_mode),
        .sync_source (sync_source),
        .field_order (field_order),
        .pin_in      (field_indicator_pin_in),
        .pin_out     (field_indicator_pin_out),
        .pin_oe      (field_indicator_pin_oe),
        .field       (field_state)
    );

    // the field state updates one edge after field_start, so sampling uses
    // the first flag of the field that is ending: not first means a new frame
    always_comb begin
        case (scan_mode)
            scan_layer_pkg::SCAN_INTERLACE: begin
                // same buffer for both fields of a frame
                buffer_sample = field_start && !field_state.first;
            end
            scan_layer_pkg::SCAN_SYNC_VIDEO: begin
                // fields are independent pictures, so each gets a fresh look
                buffer_sample = field_start;
            end
            default: begin
                buffer_sample = field_start;
            end
        endcase
    end

    // latched video buffer choice; the reset field state has first clear, so the
    // interlace case samples at the very first field start; the reset value is buffer zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            video_buffer_shown <= 1'b0;
        end else if (buffer_sample) begin
            video_buffer_shown <= video_buffer_status;
        end
    end

    // fetch only what is enabled; the enables follow register writes at once,
    // which is why software confines changes to the update interval
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fetch_enables  <= '0;
            front_depth_16 <= 1'b0;
        end else begin
            fetch_enables  <= layer_on;
            front_depth_16 <= (pixel_depth_select != `DEPTH_CODE_8BPP);
        end
    end

    // flags the state in which 16 bpp leaves no bandwidth for other layers;
    // the block does not force the enables off, software owns that choice
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            video_capture_mode_ok <= 1'b1;
        end else begin
            video_capture_mode_ok <= !(front_depth_16 && (layer_on.video ||
                                       layer_on.backdrop || layer_on.pointer1 ||
                                       layer_on.pointer2));
        end
    end

    // backdrop origin plus screen position, wide enough to catch overflow
    assign sum_x = (SCAN_X_W+1)'(backdrop_origin_x[`WID_ORIGIN_X-1:0]) +
                   (SCAN_X_W+1)'(scan_x);
    assign sum_y = (SCAN_Y_W+1)'(backdrop_origin_y[`WID_ORIGIN_Y-1:0]) +
                   (SCAN_Y_W+1)'(scan_y);

    // wrap subtracts the plane size once: X always folds back, Y only for sums below 2048; plain scroll blanks past it
    always_comb begin
        next_fetch_x   = sum_x;
        next_fetch_y   = sum_y;
        next_bg_inside = 1'b1;
        if (backdrop_wrap) begin
            if (sum_x >= BG_W) begin
                next_fetch_x = sum_x - BG_W;
            end
            if (sum_y >= BG_H) begin
                next_fetch_y = sum_y - BG_H;
            end
        end else if ((sum_x >= BG_W) || (sum_y >= BG_H)) begin
            next_bg_inside = 1'b0;
        end
    end

    // backdrop fetch address and its qualifier
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            backdrop_fetch_x     <= '0;
            backdrop_fetch_y     <= '0;
            backdrop_fetch_valid <= 1'b0;
        end else begin
            backdrop_fetch_x     <= next_fetch_x[SCAN_X_W-1:0];
            backdrop_fetch_y     <= next_fetch_y[SCAN_Y_W-1:0];
            backdrop_fetch_valid <= pixel_valid && layer_on.backdrop && next_bg_inside;
        end
    end

    // priority: pointers, front, video, backdrop; zero is transparent for
    // pointers and front, video is opaque inside its window
    always_comb begin
        next_pixel = '0;
        if (layer_on.pointer1 && (pointer1_pixel != '0)) begin
            next_pixel = pointer1_pixel;
        end else if (layer_on.pointer2 && (pointer2_pixel != '0)) begin
            next_pixel = pointer2_pixel;
        end else if (layer_on.front && (front_pixel != '0)) begin
            next_pixel = front_pixel;
        end else if (layer_on.video && video_in_window) begin
            next_pixel = video_pixel;
        end else if (layer_on.backdrop && backdrop_fetch_valid) begin
            next_pixel = backdrop_pixel;
        end
    end

    // composed pixel output, one cycle after the layer pixels
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            composed_pixel <= '0;
            composed_valid <= 1'b0;
        end else begin
            composed_pixel <= pixel_valid ? next_pixel : '0;
            composed_valid <= pixel_valid;
        end
    end

endmodule : display_scan_layer_control

// *** dv/scan_layer_assertions.sv ***
// Purpose: port assertions for the scan and layer control block
// Assumes: registers change only through reg_wr; index 5 is read-only
// Notes  : a shadow of writable indices 0 to 3 supplies the expected settings
module scan_layer_checks #(parameter int ADDR_WIDTH = 3, parameter int SCAN_X_W = 10) (
    input wire logic                  core_clk, rst, reg_wr, field_start, video_capture_mode_ok,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [15:0]           reg_wdata,
    input wire logic [SCAN_X_W-1:0]   scan_x, backdrop_fetch_x,
    input wire logic                  field_indicator_pin_in, field_indicator_pin_out,
    input wire logic                  field_indicator_pin_oe, backdrop_fetch_valid,
    input wire logic                  video_buffer_status, video_buffer_shown, front_depth_16,
    input wire scan_layer_pkg::layer_enables_t fetch_enables,
    input wire scan_layer_pkg::field_state_t   field_state
);
    logic [15:0] sh [0:3];
    logic [4:0]  en;
    logic        ord, ext, mst;
    // decoded settings; spare timing codes are left out of both groups
    assign en  = {sh[1][0], sh[1][1], sh[0][10], sh[1][2], sh[1][3]};
    assign ord = sh[1][4];
    assign ext = (sh[0][3:2] == 2'b10);
    assign mst = (sh[0][3:2] == 2'b00);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // shadow registers, so a register that never updates shows at the outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) sh <= '{16'h0000, 16'h0001, 16'h0000, 16'h0000};
        else if (reg_wr && reg_addr < 3'h4) sh[reg_addr[1:0]] <= reg_wdata;
    end
    AST_FETCH: assert property (!$past(rst) |-> fetch_enables == $past(en))
        else $error("fetch enables differ from layer bits");
    AST_DEPTH: assert property (!$past(rst) |-> front_depth_16 == ($past(sh[2][2:0]) != 3'h0))
        else $error("depth flag wrong");
    AST_CAPOK: assert property (!$past(rst) |-> video_capture_mode_ok ==
        !($past(front_depth_16) && $past(en[3:0]) != 4'h0)) else $error("capture flag wrong");
    AST_NONINT: assert property (field_start && !sh[0][1] |=> field_state == 3'b010)
        else $error("non-interlace field state wrong");
    AST_ALT: assert property (field_start && sh[0][1] && mst && field_state.interlaced
        |=> field_state.even != $past(field_state.even)) else $error("fields do not alternate");
    AST_PIN: assert property (field_start && mst |-> ##2 (field_indicator_pin_oe
        |-> field_indicator_pin_out == (field_state.even ^ ord))) else $error("pin level wrong");
    AST_EXT: assert property (field_start && ext && sh[0][1]
        |=> field_state.even == ($past(field_indicator_pin_in, 3) ^ ord)) else $error("pin read wrong");
    AST_OEX: assert property (field_start && ext |-> ##2 !field_indicator_pin_oe)
        else $error("pin driven under outside timing");
    AST_BUF: assert property (field_start && sh[0][1:0] != 2'b10
        |=> video_buffer_shown == $past(video_buffer_status)) else $error("buffer not sampled");
    AST_FRM: assert property (field_start && sh[0][1:0] == 2'b10 && field_state.first
        |=> $stable(video_buffer_shown)) else $error("buffer sampled mid-frame");
    AST_WRAP: assert property (sh[0][11] |=> backdrop_fetch_x == 10'($past(scan_x)
        + $past(sh[3][9:0]))) else $error("wrapped x wrong");
    AST_EDGE: assert property (!sh[0][11] && ({1'b0, scan_x} + {1'b0, sh[3][9:0]}) > 11'h3FF
        |=> !backdrop_fetch_valid) else $error("plain scroll ran past plane");
endmodule : scan_layer_checks
bind display_scan_layer_control scan_layer_checks #(.ADDR_WIDTH(ADDR_WIDTH), .SCAN_X_W(SCAN_X_W))
    chk (.*);

// *** dv/sync_source_model.sv ***
// Purpose: outside sync source with 20-clock fields
// Assumes: order follows the field order bit the bench writes
// Notes  : pin and buffer flag move mid-field, clear of field starts
module sync_source_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic order,
    output logic      field_start,
    output logic      pin,
    output logic      even,
    output logic      buf_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;
    // field count; parity changes mid-field so the sync flops see a steady pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt      <= 5'h00;
            even     <= 1'b0;
            buf_flag <= 1'b0;
        end else begin
            cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
            if (cnt == 5'h0A) even <= ~even;
            if (cnt == 5'h05) buf_flag <= ~buf_flag;
        end
    end
    assign field_start = (cnt == 5'h13);
    assign pin         = even ^ order;  // high in even fields with order 0
endmodule : sync_source_model

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the scan and layer control block
// Assumes: sync source model makes 20-clock fields
// Notes  : a released field pin floats high through its pull-up
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pv = 0, win = 0, ord = 0, ext = 0;
    logic [2:0]  reg_addr = 3'h0;
    logic [9:0]  sx = 10'h000;
    logic [15:0] reg_wdata = 16'h0000, p1 = 16'h0000, p2 = 16'h0000, fp = 16'h0000, rdata, cp;
    logic        fs, ppin, pev, bst, pout, poe, ev;
    scan_layer_pkg::field_state_t fst;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    display_scan_layer_control dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .field_start(fs), .pixel_valid(pv), .scan_x(sx), .scan_y(14'h0000),
        .field_indicator_pin_in(poe ? pout : (ext ? ppin : 1'b1)), .field_indicator_pin_out(pout),
        .field_indicator_pin_oe(poe), .video_buffer_status(bst), .video_buffer_shown(),
        .video_capture_mode_ok(), .fetch_enables(), .front_depth_16(), .backdrop_fetch_x(),
        .backdrop_fetch_y(), .backdrop_fetch_valid(), .field_state(fst), .front_pixel(fp),
        .video_pixel(16'h0004), .video_in_window(win), .backdrop_pixel(16'h0005),
        .pointer1_pixel(p1), .pointer2_pixel(p2), .composed_pixel(cp), .composed_valid());
    sync_source_model src (.core_clk(core_clk), .rst(rst), .order(ord), .field_start(fs),
        .pin(ppin), .even(pev), .buf_flag(bst));
    initial forever #50 core_clk = ~core_clk;
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // hang guard, roughly three and a half times the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask : rd
    // reset values; status and the two unmapped indices read zero before any field
    task automatic chk_reset();
        for (int i = 0; i < 8; i++) rd(3'(i), (i == 1) ? 16'h0001 : 16'h0000);
    endtask : chk_reset
    // settle past a field start: state lands one clock later, pin two
    task automatic fld();
        @(posedge core_clk iff fs);
        repeat (3) @(posedge core_clk);
        #1;
    endtask : fld
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk_reset();
        wr(3'h3, 16'hFFFF);
        wr(3'h4, 16'hC3FF);
        rd(3'h3, 16'h03FF);
        rd(3'h4, 16'h03FF);
        for (int d = 7; d >= 0; d--) wr(3'h2, 16'(d));
        wr(3'h0, 16'h0400);
        for (int e = 0; e < 16; e++) wr(3'h1, 16'(e));
        wr(3'h0, 16'h0C00);
        wr(3'h1, 16'h000F);
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            p1  <= (i == 0) ? 16'h0001 : 16'h0000;
            p2  <= (i < 2) ? 16'h0002 : 16'h0000;
            fp  <= (i < 3) ? 16'h0003 : 16'h0000;
            win <= (i < 4);
            pv  <= 1'b1;
            @(posedge core_clk);
            #1 chk("pixel", 16'(i + 1), cp);
        end
        wr(3'h3, 16'h03FF);
        for (int w = 0; w < 2; w++) begin
            wr(3'h0, w ? 16'h0400 : 16'h0C00);
            for (int x = 0; x < 4; x++) @(posedge core_clk) sx <= 10'(x);
        end
        for (int s = 0; s < 2; s++) begin
            for (int o = 0; o < 2; o++) begin
                for (int c = 0; c < 4; c++) begin
                    wr(3'h0, 16'h0000);
                    wr(3'h1, 16'(1 + 16 * o));
                    ord <= o[0];
                    fld();
                    wr(3'h0, 16'(c + 8 * s));
                    ext <= s[0];
                    for (int k = 0; k < 4; k++) begin
                        fld();
                        ev = s ? pev : (o[0] ^ k[0]);
                        chk("field", c[1] ? {13'h0000, ev, ev == o[0], 1'b1} : 16'h0002,
                            {13'h0000, fst});
                        chk("pin", {14'h0000, ~s[0] & c[1], ~s[0] & c[1] & (ev ^ o[0])},
                            {14'h0000, poe, poe & pout});
                    end
                end
            end
        end
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        chk_reset();
        tally_and_finish();
    end
endmodule : tb_top
